// ===== core/rims_pkg.sv
package rims_pkg;

   // Register word addresses on the plain register port.
   localparam logic [3:0] RIMS_ADDR_CTRL = 4'h0;
   localparam logic [3:0] RIMS_ADDR_MON = 4'h4;
   localparam logic [3:0] RIMS_ADDR_HOLD = 4'h8;
   localparam logic [3:0] RIMS_ADDR_STAT = 4'hc;

   // Position of the two sticky loss bits inside the status word.
   localparam int RIMS_STAT_LATCH_LSB = 2;

   // Consecutive missing divided-clock periods that declare loss.
   localparam logic [1:0] RIMS_LOS_MISS_COUNT = 2'h3;

   typedef struct packed {
      logic irq_en;
      logic int_sel;
      logic use_pin;
      logic auto_mode_hi_n;
      logic auto_mode_lo_n;
      logic holdover_on_n;
      logic pll1_bypass;
   } rims_ctrl_type;

   typedef struct packed {
      logic [7:0] revalid_count;
      logic [1:0][1:0] monitor_divider;
   } rims_mon_type;

   typedef struct packed {
      logic [15:0] holdoff_prescale;
      logic [15:0] holdoff_count;
   } rims_hold_type;

   typedef struct packed {
      logic ref_loss_flag;
      logic selected_input_flag;
      logic holdover_flag_n;
      logic [1:0] input_loss_latched;
      logic [1:0] input_loss_live;
   } rims_status_type;

   // Reset values: manual mode with holdover, monitoring on.
   localparam rims_ctrl_type RIMS_CTRL_RST = 7'h00;
   localparam rims_mon_type RIMS_MON_RST = 12'h100;
   localparam rims_hold_type RIMS_HOLD_RST = 32'h0001_0010;

   typedef enum logic [2:0] {
      RIMS_MODE_MAN_HOLD = 3'b000,
      RIMS_MODE_MAN = 3'b001,
      RIMS_MODE_AUTO = 3'b010,
      RIMS_MODE_AUTO_ALT = 3'b011,
      RIMS_MODE_SHORT_HOLD = 3'b100
   } rims_mode_type;

   typedef enum logic {
      RIMS_SEL_RUN = 1'b0,
      RIMS_SEL_HOLD = 1'b1
   } rims_sel_state_type;

endpackage : rims_pkg

// ===== core/rims_los_det.sv
`timescale 1ns/1ps
module rims_los_det (
   // Clock and control
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic en,
   // Configuration
   input wire logic [1:0] monitor_divider,
   input wire logic [7:0] revalid_count,
   // Pins
   input wire logic ref_raw,
   input wire logic diff_zero_raw,
   // Result
   output logic loss,
   output logic loss_rise
);
   import rims_pkg::*;

   logic [2:0] ref_sync_r, ref_sync_nxt, dz_sync_r, dz_sync_nxt;
   logic ref_filt_r, ref_filt_nxt, dz_filt_r, dz_filt_nxt;
   logic seen_r, seen_nxt, seen_now, tick;
   logic [1:0] div_cnt_r, div_cnt_nxt, miss_r, miss_nxt;
   logic [7:0] good_r, good_nxt;
   logic loss_r, loss_nxt;

   always_comb begin
      ref_sync_nxt = {ref_sync_r[1:0], ref_raw};
      dz_sync_nxt = {dz_sync_r[1:0], diff_zero_raw};
      ref_filt_nxt = ref_filt_r;
      dz_filt_nxt = dz_filt_r;
      seen_now = seen_r;
      if (ref_sync_r[1] == ref_sync_r[2] && ref_sync_r[2] != ref_filt_r) begin
         ref_filt_nxt = ref_sync_r[2];
         seen_now = 1'b1;
      end
      if (dz_sync_r[1] == dz_sync_r[2]) begin
         dz_filt_nxt = dz_sync_r[2];
      end
      tick = (div_cnt_r == monitor_divider);
      div_cnt_nxt = tick ? 2'h0 : div_cnt_r + 2'h1;
      seen_nxt = tick ? 1'b0 : seen_now;
      miss_nxt = miss_r;
      good_nxt = good_r;
      loss_nxt = loss_r;
      if (!en) begin
         miss_nxt = 2'h0;
         good_nxt = 8'h00;
         loss_nxt = 1'b0;
      end else if (dz_filt_r) begin
         good_nxt = 8'h00;
         loss_nxt = 1'b1;
      end else if (tick) begin
         if (seen_now) begin
            miss_nxt = 2'h0;
            if (good_r != 8'hff) begin
               good_nxt = good_r + 8'h01;
            end
         end else begin
            good_nxt = 8'h00;
            if (miss_r != RIMS_LOS_MISS_COUNT) begin
               miss_nxt = miss_r + 2'h1;
            end
         end
         if (miss_nxt == RIMS_LOS_MISS_COUNT) begin
            loss_nxt = 1'b1;
         end else if (loss_r && good_nxt >= revalid_count) begin
            loss_nxt = 1'b0;
         end
      end
      loss_rise = ce & loss_nxt & ~loss_r;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ref_sync_r <= 3'h0;
         dz_sync_r <= 3'h0;
         ref_filt_r <= 1'b0;
         dz_filt_r <= 1'b0;
         seen_r <= 1'b0;
         div_cnt_r <= 2'h0;
         miss_r <= 2'h0;
         good_r <= 8'h00;
         loss_r <= 1'b0;
      end else if (ce) begin
         ref_sync_r <= ref_sync_nxt;
         dz_sync_r <= dz_sync_nxt;
         ref_filt_r <= ref_filt_nxt;
         dz_filt_r <= dz_filt_nxt;
         seen_r <= seen_nxt;
         div_cnt_r <= div_cnt_nxt;
         miss_r <= miss_nxt;
         good_r <= good_nxt;
         loss_r <= loss_nxt;
      end
   end

   assign loss = loss_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   property p_los_needs_three;
      $rose(loss_r) |-> ($past(miss_r) == 2'h2) || $past(dz_filt_r);
   endproperty
   a_los_needs_three: assert property (p_los_needs_three)
      else $error("loss declared without three missing periods");

   property p_revalid_count;
      $fell(loss_r) && $past(en) |->
         ({1'b0, $past(good_r)} + 9'h001) >= {1'b0, $past(revalid_count)};
   endproperty
   a_revalid_count: assert property (p_revalid_count)
      else $error("input revalidated too early");

endmodule : rims_los_det

// ===== core/rims_ref_monitor.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module rims_ref_monitor (
   // Clock, reset and enable
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Reference pins
   input wire logic [1:0] ref_in,
   input wire logic [1:0] ref_diff_zero,
   input wire logic select_pin,
   // Selection and alarm outputs
   output logic ref_select,
   output logic holdover_active,
   output logic irq_out_n
);
   import rims_pkg::*;

   rims_ctrl_type ctrl_r, ctrl_nxt;
   rims_mon_type mon_r, mon_nxt;
   rims_hold_type hold_r, hold_nxt;
   rims_status_type status;
   logic [1:0] latched_r, latched_nxt, latch_clr;
   logic [31:0] rdata_r, rdata_nxt;
   logic irq_r, irq_nxt;
   logic [1:0] live, loss_rise;
   logic [2:0] sel_sync_r, sel_sync_nxt;
   logic sel_filt_r, sel_filt_nxt;
   rims_mode_type mode;
   rims_sel_state_type state_r, state_nxt;
   logic active_r, active_nxt, user_prev_r, user_prev_nxt, user_sel;
   logic [31:0] tot_r, tot_nxt;

   // One detector per reference input.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_det
         rims_los_det u_det (
            .clock(clock),
            .rst(rst),
            .ce(ce),
            .en(~ctrl_r.pll1_bypass),
            .monitor_divider(mon_r.monitor_divider[gi]),
            .revalid_count(mon_r.revalid_count),
            .ref_raw(ref_in[gi]),
            .diff_zero_raw(ref_diff_zero[gi]),
            .loss(live[gi]),
            .loss_rise(loss_rise[gi])
         );
      end
   endgenerate

   // Register file, read data and interrupt.
   always_comb begin
      ctrl_nxt = ctrl_r;
      mon_nxt = mon_r;
      hold_nxt = hold_r;
      latch_clr = 2'h0;
      if (reg_wr) begin
         case (reg_addr)
            RIMS_ADDR_CTRL: ctrl_nxt = reg_wdata[$bits(rims_ctrl_type)-1:0];
            RIMS_ADDR_MON: mon_nxt = reg_wdata[$bits(rims_mon_type)-1:0];
            RIMS_ADDR_HOLD: hold_nxt = reg_wdata;
            RIMS_ADDR_STAT: latch_clr = reg_wdata[RIMS_STAT_LATCH_LSB +: 2];
            default: latch_clr = 2'h0;
         endcase
      end
      latched_nxt = (latched_r & ~latch_clr) | loss_rise;
      rdata_nxt = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            RIMS_ADDR_CTRL: rdata_nxt = {25'h0, ctrl_r};
            RIMS_ADDR_MON: rdata_nxt = {20'h0, mon_r};
            RIMS_ADDR_HOLD: rdata_nxt = hold_r;
            RIMS_ADDR_STAT: rdata_nxt = {25'h0, status};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      irq_nxt = ctrl_r.irq_en & (|latched_nxt);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_r <= RIMS_CTRL_RST;
         mon_r <= RIMS_MON_RST;
         hold_r <= RIMS_HOLD_RST;
         latched_r <= 2'h0;
         rdata_r <= 32'h0000_0000;
         irq_r <= 1'b0;
      end else if (ce) begin
         ctrl_r <= ctrl_nxt;
         mon_r <= mon_nxt;
         hold_r <= hold_nxt;
         latched_r <= latched_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Selection pin synchroniser; a change counts once two stages agree.
   always_comb begin
      sel_sync_nxt = {sel_sync_r[1:0], select_pin};
      sel_filt_nxt = sel_filt_r;
      if (sel_sync_r[1] == sel_sync_r[2]) begin
         sel_filt_nxt = sel_sync_r[2];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sel_sync_r <= 3'h0;
         sel_filt_r <= 1'b0;
      end else if (ce) begin
         sel_sync_r <= sel_sync_nxt;
         sel_filt_r <= sel_filt_nxt;
      end
   end

   // Mode decode and reference selector.
   always_comb begin
      if (!ctrl_r.holdover_on_n) begin
         mode = RIMS_MODE_MAN_HOLD;
      end else begin
         case ({ctrl_r.auto_mode_hi_n, ctrl_r.auto_mode_lo_n})
            2'b00: mode = RIMS_MODE_MAN;
            2'b01: mode = RIMS_MODE_AUTO;
            2'b10: mode = RIMS_MODE_SHORT_HOLD;
            default: mode = RIMS_MODE_AUTO_ALT;
         endcase
      end
      user_sel = ctrl_r.use_pin ? sel_filt_r : ctrl_r.int_sel;
      state_nxt = state_r;
      active_nxt = active_r;
      tot_nxt = tot_r;
      user_prev_nxt = user_sel;
      case (state_r)
         RIMS_SEL_RUN: begin
            case (mode)
               RIMS_MODE_MAN_HOLD, RIMS_MODE_SHORT_HOLD: begin
                  if (user_sel != active_r) begin
                     state_nxt = RIMS_SEL_HOLD;
                     tot_nxt = 32'(hold_r.holdoff_count) * 32'(hold_r.holdoff_prescale);
                  end
               end
               RIMS_MODE_MAN: active_nxt = user_sel;
               default: begin
                  if (live[active_r] && !live[~active_r]) begin
                     active_nxt = ~active_r;
                  end else if (user_sel != user_prev_r) begin
                     active_nxt = user_sel;
                  end
               end
            endcase
         end
         RIMS_SEL_HOLD: begin
            if (tot_r <= 32'h0000_0001) begin
               state_nxt = RIMS_SEL_RUN;
               active_nxt = user_sel;
            end else begin
               tot_nxt = tot_r - 32'h0000_0001;
            end
         end
         default: state_nxt = RIMS_SEL_RUN;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= RIMS_SEL_RUN;
         active_r <= 1'b0;
         user_prev_r <= 1'b0;
         tot_r <= 32'h0000_0000;
      end else if (ce) begin
         state_r <= state_nxt;
         active_r <= active_nxt;
         user_prev_r <= user_prev_nxt;
         tot_r <= tot_nxt;
      end
   end

   assign status.ref_loss_flag = (mode == RIMS_MODE_MAN_HOLD) ? 1'b0 : live[active_r];
   assign status.selected_input_flag = active_r;
   assign status.holdover_flag_n = (state_r != RIMS_SEL_HOLD);
   assign status.input_loss_latched = latched_r;
   assign status.input_loss_live = live;

   assign reg_rdata = rdata_r;
   assign ref_select = active_r;
   assign holdover_active = (state_r == RIMS_SEL_HOLD);
   assign irq_out_n = ~irq_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   property p_bypass_clears_live;
      ctrl_r.pll1_bypass && ce |=> live == 2'h0;
   endproperty
   a_bypass_clears_live: assert property (p_bypass_clears_live)
      else $error("loss detection active while bypassed");

   property p_sticky_on_loss;
      $rose(live[0]) |-> latched_r[0];
   endproperty
   a_sticky_on_loss: assert property (p_sticky_on_loss)
      else $error("sticky flag missed a loss event");

   property p_sticky_holds;
      latched_r[1] && !(reg_wr && reg_addr == RIMS_ADDR_STAT && reg_wdata[3]) |=> latched_r[1];
   endproperty
   a_sticky_holds: assert property (p_sticky_holds)
      else $error("sticky flag cleared without software");

   property p_man_hold_flags;
      state_r == RIMS_SEL_RUN && mode == RIMS_MODE_MAN_HOLD && user_sel == active_r && ce
         |-> (!status.ref_loss_flag && status.holdover_flag_n)
         ##1 (active_r == $past(active_r) && state_r == RIMS_SEL_RUN);
   endproperty
   a_man_hold_flags: assert property (p_man_hold_flags)
      else $error("reference loss flag set in manual holdover");

   property p_enter_hold;
      state_r == RIMS_SEL_RUN && mode == RIMS_MODE_MAN_HOLD && user_sel != active_r && ce
         |=> state_r == RIMS_SEL_HOLD && active_r == $past(active_r);
   endproperty
   a_enter_hold: assert property (p_enter_hold)
      else $error("manual change did not enter holdover");

   property p_hold_expiry;
      state_r == RIMS_SEL_HOLD && tot_r == 32'h0000_0001 && ce
         |=> state_r == RIMS_SEL_RUN && active_r == $past(user_sel);
   endproperty
   a_hold_expiry: assert property (p_hold_expiry)
      else $error("holdover did not end at counter expiry");

   property p_manual_direct;
      state_r == RIMS_SEL_RUN && mode == RIMS_MODE_MAN && ce |=> active_r == $past(user_sel);
   endproperty
   a_manual_direct: assert property (p_manual_direct)
      else $error("manual mode did not follow selection");

   property p_auto_failover;
      state_r == RIMS_SEL_RUN && mode == RIMS_MODE_AUTO && live[active_r] && !live[~active_r]
         && ce |=> active_r != $past(active_r) && state_r == RIMS_SEL_RUN;
   endproperty
   a_auto_failover: assert property (p_auto_failover)
      else $error("automatic mode did not switch on loss");

   property p_irq_masked;
      !ctrl_r.irq_en && ce |=> irq_out_n;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt asserted while disabled");

   property p_pin_select;
      state_r == RIMS_SEL_RUN && mode == RIMS_MODE_MAN && ctrl_r.use_pin && ce
         |=> active_r == $past(sel_filt_r);
   endproperty
   a_pin_select: assert property (p_pin_select)
      else $error("pin selection not followed");

   c_hold_expire: cover property (state_r == RIMS_SEL_HOLD ##1 state_r == RIMS_SEL_RUN);
   c_enter_hold: cover property (state_r == RIMS_SEL_RUN ##1 state_r == RIMS_SEL_HOLD);
   c_auto_switch: cover property (mode == RIMS_MODE_AUTO && $changed(active_r));
   c_loss_rise: cover property ($rose(live[1]));

endmodule : rims_ref_monitor

// ===== test/rims_ref_src.sv
`timescale 1ns/1ps
module rims_ref_src (
   // Bench control
   input wire logic [1:0] run,
   input wire logic [1:0] null_diff,
   input wire logic [31:0] half0_ns,
   input wire logic [31:0] half1_ns,
   // Reference pins
   output logic [1:0] ref_in,
   output logic [1:0] ref_diff_zero
);
   logic l0 = 1'b0;
   logic l1 = 1'b0;

   // A stopped source holds its last level, which is how a dead input looks.
   // The two sources run at unrelated phases to the monitor clock.
   initial begin
      #37;
      forever begin
         #(half0_ns);
         if (run[0]) begin
            l0 = ~l0;
         end
      end
   end

   initial begin
      #61;
      forever begin
         #(half1_ns);
         if (run[1]) begin
            l1 = ~l1;
         end
      end
   end

   // Edges keep coming while the pair is nulled, so only the null flag shows it.
   assign ref_in = {l1, l0};
   assign ref_diff_zero = null_diff;
endmodule : rims_ref_src

// ===== test/rims_ref_monitor_tb_top.sv
`timescale 1ns/1ps
module rims_ref_monitor_tb_top;
   import rims_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [1:0] ref_in;
   logic [1:0] ref_diff_zero;
   logic select_pin = 1'b0;
   logic ref_select;
   logic holdover_active;
   logic irq_out_n;
   logic [1:0] src_run = 2'b11;
   logic [1:0] src_null = 2'b00;
   int half0 = 100;
   int half1 = 100;
   int n_mismatch = 0;
   int n_checks = 0;
   int m_live [2] = '{0, 0};
   int m_latch [2] = '{0, 0};
   bit q_sel [$];
   logic [31:0] rd_v;
   logic [31:0] modes [5] = '{32'h02, 32'h06, 32'h0a, 32'h0e, 32'h0c};
   int n;
   int k;

   initial begin
      forever begin
         #25 clock = ~clock;
      end
   end

   rims_ref_monitor DUT (
      .clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_in(ref_in),
      .ref_diff_zero(ref_diff_zero), .select_pin(select_pin), .ref_select(ref_select),
      .holdover_active(holdover_active), .irq_out_n(irq_out_n)
   );

   rims_ref_src src (
      .run(src_run), .null_diff(src_null), .half0_ns(half0), .half1_ns(half1),
      .ref_in(ref_in), .ref_diff_zero(ref_diff_zero)
   );

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int c);
      repeat (c) @(posedge clock);
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask : rd

   // Compares the four loss bits with the model's view of both inputs.
   task automatic chk_stat();
      rd(RIMS_ADDR_STAT, rd_v);
      chk("loss bits", 32'((m_latch[1] << 3) | (m_latch[0] << 2) | (m_live[1] << 1) | m_live[0]),
         rd_v & 32'hf);
   endtask : chk_stat

   // Polls the live flag; a bound that runs out ends the run.
   task automatic wait_live(input int i, input logic v);
      for (int j = 0; j < 40; j++) begin
         rd(RIMS_ADDR_STAT, rd_v);
         if (rd_v[i] === v) begin
            m_live[i] = int'(v);
            m_latch[i] = m_latch[i] | int'(v);
            return;
         end
      end
      chk("live wait", 32'(v), 32'(rd_v[i]));
      summarize();
   endtask : wait_live

   initial begin
      void'($urandom(84096));
      cyc(3);
      rst <= 1'b0;
      rd(RIMS_ADDR_CTRL, rd_v);
      chk("ctrl reset", 32'(RIMS_CTRL_RST), rd_v);
      rd(RIMS_ADDR_MON, rd_v);
      chk("mon reset", 32'(RIMS_MON_RST), rd_v);
      rd(RIMS_ADDR_HOLD, rd_v);
      chk("hold reset", 32'(RIMS_HOLD_RST), rd_v);
      wr(4'h2, 32'hffff_ffff);
      rd(4'h2, rd_v);
      chk("unmapped", 32'h0, rd_v);
      rd(RIMS_ADDR_CTRL, rd_v);
      chk("ctrl kept", 32'(RIMS_CTRL_RST), rd_v);
      // A strobe while the clock enable is low must leave every register alone.
      @(posedge clock);
      ce <= 1'b0;
      wr(RIMS_ADDR_CTRL, 32'h7f);
      ce <= 1'b1;
      rd(RIMS_ADDR_CTRL, rd_v);
      chk("ctrl frozen", 32'(RIMS_CTRL_RST), rd_v);
      // Sources run at a quarter of the clock, so both dividers are set to three, a four-cycle window.
      wr(RIMS_ADDR_MON, 32'h04f);
      cyc(30);
      wr(RIMS_ADDR_STAT, 32'hc);
      chk_stat();
      src_run[1] <= 1'b0;
      cyc(4);
      rd(RIMS_ADDR_STAT, rd_v);
      chk("early loss", 32'h0, 32'(rd_v[1]));
      wait_live(1, 1'b1);
      chk_stat();
      chk("irq masked", 32'h1, 32'(irq_out_n));
      wr(RIMS_ADDR_CTRL, 32'h40);
      cyc(2);
      chk("irq low", 32'h0, 32'(irq_out_n));
      src_run[1] <= 1'b1;
      cyc(8);
      rd(RIMS_ADDR_STAT, rd_v);
      chk("early valid", 32'h1, 32'(rd_v[1]));
      wait_live(1, 1'b0);
      chk_stat();
      wr(RIMS_ADDR_STAT, 32'h8);
      m_latch[1] = 0;
      chk_stat();
      chk("irq clear", 32'h1, 32'(irq_out_n));
      src_null[0] <= 1'b1;
      wait_live(0, 1'b1);
      src_null[0] <= 1'b0;
      wait_live(0, 1'b0);
      wr(RIMS_ADDR_STAT, 32'h4);
      m_latch[0] = 0;
      chk_stat();
      // Bypassed: monitoring is off, so a dead input raises nothing.
      wr(RIMS_ADDR_CTRL, 32'h41); // selection kept manual
      src_run[1] <= 1'b0;
      cyc(40);
      chk_stat();
      chk("irq bypass", 32'h1, 32'(irq_out_n));
      src_run[1] <= 1'b1;
      wr(RIMS_ADDR_CTRL, 32'h40);
      cyc(30);
      half0 <= 200;
      cyc(40);
      chk_stat();
      wr(RIMS_ADDR_MON, 32'h04c);
      wait_live(0, 1'b1);
      wr(RIMS_ADDR_MON, 32'h04f);
      half0 <= 100;
      wait_live(0, 1'b0);
      wr(RIMS_ADDR_STAT, 32'hc);
      m_latch = '{0, 0};
      for (int m = 0; m < 5; m++) begin
         wr(RIMS_ADDR_CTRL, modes[m]);
         cyc(2);
         src_run[0] <= 1'b0;
         wait_live(0, 1'b1);
         cyc(4);
         chk("mode sel", 32'(m == 1 || m == 3), 32'(ref_select));
         chk("mode hold", 32'h0, 32'(holdover_active));
         rd(RIMS_ADDR_STAT, rd_v);
         if (m == 0 || m == 4) begin
            chk("ref loss", 32'(m == 0), 32'(rd_v[6]));
         end
         src_run[0] <= 1'b1;
         wait_live(0, 1'b0);
         wr(RIMS_ADDR_CTRL, 32'h02);
         cyc(2);
         chk("manual back", 32'h0, 32'(ref_select));
      end
      wr(RIMS_ADDR_HOLD, 32'h0003_0002);
      wr(RIMS_ADDR_CTRL, 32'h00);
      src_run[1] <= 1'b0;
      wait_live(1, 1'b1);
      wr(RIMS_ADDR_CTRL, 32'h20);
      k = 0;
      for (n = 0; n < 50; n++) begin
         @(negedge clock);
         if (holdover_active === 1'b1) begin
            k++;
            if (k == 1) begin
               chk("sel held", 32'h0, 32'(ref_select));
            end
         end else if (k > 0) begin
            break;
         end
      end
      chk("holdover len", 32'd6, 32'(k));
      chk("sel new", 32'h1, 32'(ref_select));
      rd(RIMS_ADDR_STAT, rd_v);
      chk("hold flags", 32'h32, rd_v & 32'h72);
      src_run[1] <= 1'b1;
      wait_live(1, 1'b0);
      wr(RIMS_ADDR_CTRL, 32'h12);
      // Let the selector settle onto the idle pin before the random walk starts.
      cyc(2);
      for (n = 0; n < 8; n++) begin
         q_sel.push_back(1'($urandom % 2));
         select_pin <= q_sel[$];
         for (k = 0; k < 8 && ref_select !== q_sel[0]; k++) begin
            @(negedge clock);
         end
         chk("pin sel", 32'(q_sel.pop_front()), 32'(ref_select));
         chk("pin hold", 32'h0, 32'(holdover_active));
         @(posedge clock);
      end
      summarize();
   end
endmodule : rims_ref_monitor_tb_top
